// *** rtl/ilf_datapath.v ***
// Link handler, SCSI DMA, FIFO banks, bus isolator and disk indicator.
`timescale 1ns/1ns
`include "ilf_defs.vh"

module ilf_datapath #(
  parameter DEPTH      = 16,
  parameter AW         = 4,
  parameter BLINK_HALF = `ILF_BLINK_HALF_CYC
) (
  input  wire        ref_clk,
  input  wire        reset,
  input  wire        clkEn,
  input  wire        lnkRxValid,
  input  wire [7:0]  lnkRxData,
  input  wire        lnkRxLast,
  output wire        lnkRxReady,
  input  wire        lnkTxStart,
  input  wire [15:0] lnkTxLen,
  input  wire        lnkTxReady,
  output reg         lnkTxValid_q,
  output reg  [7:0]  lnkTxData_q,
  output reg         lnkTxLast_q,
  input  wire        scsiDmaEn,
  input  wire        scsiReqIn,
  input  wire        scsiDirIn,
  input  wire [7:0]  scsiDataIn,
  input  wire        scsiParIn,
  output reg  [7:0]  scsiDataOut_q,
  output reg         scsiParOut_q,
  output reg         scsiDataOe_q,
  output reg         scsiAckOut_q,
  input  wire        isoReq,
  output reg         isoState_q,
  input  wire        mpuReq,
  input  wire        mpuWr,
  input  wire [2:0]  mpuAddr,
  input  wire [7:0]  mpuWdata,
  output reg         mpuAck_q,
  output reg         mpuRefused_q,
  output reg  [7:0]  mpuRdata_q,
  input  wire [2:0]  errClr,
  output reg  [2:0]  err_q,
  input  wire        diskSpinIn,
  input  wire        diskSpeedIn,
  output reg         led_q
);

  localparam [1:0] LT_IDLE = 2'h0;
  localparam [1:0] LT_DATA = 2'h1;
  localparam [1:0] LT_CRC  = 2'h2;
  localparam [1:0] SC_IDLE = 2'h0;
  localparam [1:0] SC_DRV  = 2'h1;
  localparam [1:0] SC_ACK  = 2'h2;
  localparam [31:0] BLINK_LAST = BLINK_HALF - 1;

  // ----------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------
  function [7:0] crc8;
    input [7:0] c;
    input [7:0] d;
    integer i;
    reg [7:0] r;
    begin
      r = c ^ d;
      for (i = 0; i < 8; i = i + 1) begin
        r = r[7] ? ({r[6:0], 1'b0} ^ `ILF_CRC_POLY) : {r[6:0], 1'b0};
      end
      crc8 = r;
    end
  endfunction

  function oddPar;
    input [7:0] d;
    begin
      oddPar = ~^d;
    end
  endfunction

  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  reg  [1:0]  ltState_q;
  reg  [15:0] ltCnt_q;
  reg  [7:0]  txCrc_q;
  reg  [7:0]  rxCrc_q;
  reg  [1:0]  scState_q;
  reg  [12:0] sync1_q;
  reg  [12:0] sync2_q;
  reg  [7:0]  scsiReg_q [0:3];
  reg  [31:0] blinkCnt_q;
  reg         blink_q;
  wire        reqS;
  wire        dirS;
  wire [7:0]  dataS;
  wire        parS;
  wire        spinS;
  wire        speedS;
  wire        scsiActive;
  wire        slotFree;
  wire        lnkPush;
  wire        lnkPop;
  wire        scsiPush;
  wire        scsiPop;
  wire        mpuFifoOk;
  wire        mpuPush;
  wire        mpuPop;
  wire        txWrRdy;
  wire        txRdVld;
  wire [7:0]  txRdData;
  wire        txParErr;
  wire        rxWrRdy;
  wire        rxRdVld;
  wire [7:0]  rxRdData;
  wire        rxParErr;
  wire [2:0]  errSet;
  wire [7:0]  status;

  // ----------------------------------------------------------------
  // Pin synchronisers.
  // ----------------------------------------------------------------
  always @(posedge ref_clk) begin
    if (reset) begin
      sync1_q <= 13'h0000;
      sync2_q <= 13'h0000;
    end else if (clkEn) begin
      sync1_q <= {diskSpeedIn, diskSpinIn, scsiParIn, scsiDataIn, scsiDirIn, scsiReqIn};
      sync2_q <= sync1_q;
    end
  end

  assign reqS   = sync2_q[0];
  assign dirS   = sync2_q[1];
  assign dataS  = sync2_q[9:2];
  assign parS   = sync2_q[10];
  assign spinS  = sync2_q[11];
  assign speedS = sync2_q[12];

  // ----------------------------------------------------------------
  // FIFO banks and their port arbitration.
  // ----------------------------------------------------------------
  assign scsiActive = scsiDmaEn && isoState_q;
  assign slotFree   = !lnkTxValid_q || lnkTxReady;
  assign lnkPush    = lnkRxValid && txWrRdy && !lnkRxLast;
  assign lnkPop     = (ltState_q == LT_DATA) && slotFree && (ltCnt_q != 16'h0000) && rxRdVld;
  assign scsiPush   = scsiActive && (scState_q == SC_IDLE) && reqS && dirS && rxWrRdy;
  assign scsiPop    = scsiActive && (scState_q == SC_IDLE) && reqS && !dirS && txRdVld;
  assign mpuFifoOk  = mpuReq && !isoState_q && (mpuAddr == `ILF_ADDR_FIFO);
  assign mpuPush    = mpuFifoOk && mpuWr && txWrRdy && !lnkPush;
  assign mpuPop     = mpuFifoOk && !mpuWr && rxRdVld && !lnkPop;
  assign lnkRxReady = txWrRdy;

  ilf_fifo #(.W(8), .DEPTH(DEPTH), .AW(AW)) txBank (
    .ref_clk  (ref_clk),
    .reset    (reset),
    .clkEn    (clkEn),
    .wrEn     (lnkPush || mpuPush),
    .wrData   (lnkPush ? lnkRxData : mpuWdata),
    .rdEn     (scsiPop),
    .wrRdy_q  (txWrRdy),
    .rdVld_q  (txRdVld),
    .rdData   (txRdData),
    .rdParErr (txParErr)
  );

  ilf_fifo #(.W(8), .DEPTH(DEPTH), .AW(AW)) rxBank (
    .ref_clk  (ref_clk),
    .reset    (reset),
    .clkEn    (clkEn),
    .wrEn     (scsiPush),
    .wrData   (dataS),
    .rdEn     (lnkPop || mpuPop),
    .wrRdy_q  (rxWrRdy),
    .rdVld_q  (rxRdVld),
    .rdData   (rxRdData),
    .rdParErr (rxParErr)
  );

  // ----------------------------------------------------------------
  // Link receive CRC check.
  // ----------------------------------------------------------------
  always @(posedge ref_clk) begin
    if (reset) begin
      rxCrc_q <= `ILF_CRC_INIT;
    end else if (clkEn) begin
      if (lnkRxValid && txWrRdy) begin
        rxCrc_q <= lnkRxLast ? `ILF_CRC_INIT : crc8(rxCrc_q, lnkRxData);
      end
    end
  end

  // ----------------------------------------------------------------
  // Link transmit DMA with appended CRC.
  // ----------------------------------------------------------------
  always @(posedge ref_clk) begin
    if (reset) begin
      ltState_q    <= LT_IDLE;
      ltCnt_q      <= 16'h0000;
      txCrc_q      <= `ILF_CRC_INIT;
      lnkTxValid_q <= 1'b0;
      lnkTxData_q  <= `ILF_RST_BYTE;
      lnkTxLast_q  <= 1'b0;
    end else if (clkEn) begin
      if (slotFree) begin
        lnkTxValid_q <= 1'b0;
        lnkTxLast_q  <= 1'b0;
      end
      case (ltState_q)
        LT_IDLE: begin
          if (lnkTxStart) begin
            ltCnt_q   <= lnkTxLen;
            txCrc_q   <= `ILF_CRC_INIT;
            ltState_q <= LT_DATA;
          end
        end
        LT_DATA: begin
          if (lnkPop) begin
            lnkTxValid_q <= 1'b1;
            lnkTxData_q  <= rxRdData;
            txCrc_q      <= crc8(txCrc_q, rxRdData);
            ltCnt_q      <= ltCnt_q - 16'h0001;
          end else if (ltCnt_q == 16'h0000) begin
            ltState_q <= LT_CRC;
          end
        end
        LT_CRC: begin
          if (slotFree) begin
            lnkTxValid_q <= 1'b1;
            lnkTxData_q  <= txCrc_q;
            lnkTxLast_q  <= 1'b1;
            ltState_q    <= LT_IDLE;
          end
        end
        default: begin
          ltState_q <= LT_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // SCSI DMA handshake with parity.
  // ----------------------------------------------------------------
  always @(posedge ref_clk) begin
    if (reset) begin
      scState_q     <= SC_IDLE;
      scsiDataOut_q <= `ILF_RST_BYTE;
      scsiParOut_q  <= 1'b0;
      scsiDataOe_q  <= 1'b0;
      scsiAckOut_q  <= 1'b0;
    end else if (clkEn) begin
      scsiDataOe_q <= scsiActive && !dirS;
      case (scState_q)
        SC_IDLE: begin
          if (scsiPush) begin
            scsiAckOut_q <= 1'b1;
            scState_q    <= SC_ACK;
          end else if (scsiPop) begin
            scsiDataOut_q <= txRdData;
            scsiParOut_q  <= oddPar(txRdData);
            scState_q     <= SC_DRV;
          end
        end
        SC_DRV: begin
          scsiAckOut_q <= 1'b1;
          scState_q    <= SC_ACK;
        end
        SC_ACK: begin
          if (!reqS) begin
            scsiAckOut_q <= 1'b0;
            scState_q    <= SC_IDLE;
          end
        end
        default: begin
          scState_q <= SC_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Isolator, processor port and SCSI internal registers.
  // ----------------------------------------------------------------
  assign status = {(scState_q != SC_IDLE), (ltState_q != LT_IDLE), rxRdVld, txRdVld,
                   err_q, isoState_q};

  always @(posedge ref_clk) begin
    if (reset) begin
      isoState_q   <= 1'b0;
      mpuAck_q     <= 1'b0;
      mpuRefused_q <= 1'b0;
      mpuRdata_q   <= `ILF_RST_BYTE;
      scsiReg_q[0] <= `ILF_RST_BYTE;
      scsiReg_q[1] <= `ILF_RST_BYTE;
      scsiReg_q[2] <= `ILF_RST_BYTE;
      scsiReg_q[3] <= `ILF_RST_BYTE;
    end else if (clkEn) begin
      isoState_q   <= isoReq;
      mpuAck_q     <= mpuReq;
      mpuRefused_q <= 1'b0;
      mpuRdata_q   <= `ILF_RST_BYTE;
      if (mpuReq) begin
        if (mpuAddr == `ILF_ADDR_STAT) begin
          mpuRdata_q <= status;
        end else if (isoState_q) begin
          mpuRefused_q <= 1'b1;
        end else if (mpuAddr[`ILF_SCSI_REG_BIT]) begin
          if (mpuWr) begin
            scsiReg_q[mpuAddr[1:0]] <= mpuWdata;
          end else begin
            mpuRdata_q <= scsiReg_q[mpuAddr[1:0]];
          end
        end else if (mpuAddr == `ILF_ADDR_FIFO) begin
          if (mpuPop) begin
            mpuRdata_q <= rxRdData;
          end else if (!mpuPush) begin
            mpuRefused_q <= 1'b1;
          end
        end else begin
          mpuRefused_q <= 1'b1;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Sticky error flags.
  // ----------------------------------------------------------------
  assign errSet[0] = lnkRxValid && txWrRdy && lnkRxLast && (lnkRxData != rxCrc_q);
  assign errSet[1] = scsiPush && !(^{dataS, parS});
  assign errSet[2] = (scsiPop && txParErr) || ((lnkPop || mpuPop) && rxParErr);

  always @(posedge ref_clk) begin
    if (reset) begin
      err_q <= `ILF_RST_ERR;
    end else if (clkEn) begin
      err_q <= errSet | (err_q & ~errClr);
    end
  end

  // ----------------------------------------------------------------
  // Faceplate indicator.
  // ----------------------------------------------------------------
  always @(posedge ref_clk) begin
    if (reset) begin
      blinkCnt_q <= 32'h00000000;
      blink_q    <= 1'b0;
      led_q      <= 1'b0;
    end else if (clkEn) begin
      if (blinkCnt_q >= BLINK_LAST) begin
        blinkCnt_q <= 32'h00000000;
        blink_q    <= ~blink_q;
      end else begin
        blinkCnt_q <= blinkCnt_q + 32'h00000001;
      end
      if (speedS) begin
        led_q <= 1'b1;
      end else if (spinS) begin
        led_q <= blink_q;
      end else begin
        led_q <= 1'b0;
      end
    end
  end

endmodule // ilf_datapath

// *** rtl/ilf_defs.vh ***
// Shared constants of the image loader FIFO datapath.
`ifndef ILF_DEFS_VH
`define ILF_DEFS_VH

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define ILF_CLK_PERIOD_NS 4
`define ILF_BLINK_HALF_MS 250
`define ILF_BLINK_HALF_CYC (`ILF_BLINK_HALF_MS * (1000000 / `ILF_CLK_PERIOD_NS))

// ----------------------------------------------------------------
// Check codes
// ----------------------------------------------------------------
`define ILF_CRC_POLY 8'h07
`define ILF_CRC_INIT 8'hFF

// ----------------------------------------------------------------
// Microprocessor port addresses
// ----------------------------------------------------------------
`define ILF_ADDR_FIFO 3'h0
`define ILF_ADDR_STAT 3'h1
`define ILF_SCSI_REG_BIT 2

// ----------------------------------------------------------------
// Status byte field positions
// ----------------------------------------------------------------
`define ILF_ST_ISO 0
`define ILF_ST_CRC 1
`define ILF_ST_SPAR 2
`define ILF_ST_FPAR 3
`define ILF_ST_TXVLD 4
`define ILF_ST_RXVLD 5
`define ILF_ST_LBUSY 6
`define ILF_ST_SBUSY 7

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define ILF_RST_ERR 3'h0
`define ILF_RST_BYTE 8'h00

`endif

// *** rtl/ilf_fifo.v ***
// Parity-protected flip-flop FIFO bank.
`timescale 1ns/1ns
`include "ilf_defs.vh"

module ilf_fifo #(
  parameter W     = 8,
  parameter DEPTH = 16,
  parameter AW    = 4
) (
  input  wire         ref_clk,
  input  wire         reset,
  input  wire         clkEn,
  input  wire         wrEn,
  input  wire [W-1:0] wrData,
  input  wire         rdEn,
  output reg          wrRdy_q,
  output reg          rdVld_q,
  output wire [W-1:0] rdData,
  output wire         rdParErr
);

  localparam [31:0] DEPTH_W = DEPTH;
  localparam [AW:0] FULL    = DEPTH_W[AW:0];

  reg  [W:0]  mem [0:DEPTH-1];
  reg  [AW-1:0] wrPtr_q;
  reg  [AW-1:0] rdPtr_q;
  reg  [AW:0] cnt_q;
  wire        push;
  wire        pop;
  wire [AW:0] cnt_d;

  assign push     = wrEn && wrRdy_q;
  assign pop      = rdEn && rdVld_q;
  assign cnt_d    = cnt_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
  assign rdData   = mem[rdPtr_q][W-1:0];
  assign rdParErr = ^mem[rdPtr_q];

  // ----------------------------------------------------------------
  // Storage, pointers and flags.
  // ----------------------------------------------------------------
  always @(posedge ref_clk) begin
    if (reset) begin
      wrPtr_q <= {AW{1'b0}};
      rdPtr_q <= {AW{1'b0}};
      cnt_q   <= {(AW+1){1'b0}};
      wrRdy_q <= 1'b0;
      rdVld_q <= 1'b0;
    end else if (clkEn) begin
      if (push) begin
        mem[wrPtr_q] <= {^wrData, wrData};
        wrPtr_q      <= wrPtr_q + 1'b1;
      end
      if (pop) begin
        rdPtr_q <= rdPtr_q + 1'b1;
      end
      cnt_q   <= cnt_d;
      wrRdy_q <= (cnt_d != FULL);
      rdVld_q <= (cnt_d != {(AW+1){1'b0}});
    end
  end

endmodule // ilf_fifo

// *** verif/ilf_datapath_chk.sv ***
// Port assertions of the image loader FIFO datapath.
`timescale 1ns/1ns
`include "ilf_defs.vh"
module ilf_datapath_chk (
  input logic       ref_clk,
  input logic       reset,
  input logic       clkEn,
  input logic       lnkTxReady,
  input logic       lnkTxValid_q,
  input logic [7:0] lnkTxData_q,
  input logic       lnkTxLast_q,
  input logic [7:0] scsiDataOut_q,
  input logic       scsiParOut_q,
  input logic       scsiDataOe_q,
  input logic       scsiAckOut_q,
  input logic       isoReq,
  input logic       isoState_q,
  input logic       mpuReq,
  input logic [2:0] mpuAddr,
  input logic       mpuAck_q,
  input logic       mpuRefused_q,
  input logic [7:0] mpuRdata_q,
  input logic [2:0] errClr,
  input logic [2:0] err_q,
  input logic       diskSpinIn,
  input logic       diskSpeedIn,
  input logic       led_q
);
  logic [2:0] keepQ;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);
  // Error bits that were set and not cleared on the last edge.
  always @(posedge ref_clk) keepQ <= reset ? 3'h0 : (err_q & ~errClr);
  property p_errSticky; (err_q & keepQ) == keepQ; endproperty
  a_errSticky: assert property (p_errSticky) else $error("error bit lost");
  property p_ackPulse; !$past(reset) && $past(clkEn) |-> mpuAck_q == $past(mpuReq); endproperty
  a_ackPulse: assert property (p_ackPulse) else $error("ack not one cycle after request");
  property p_refusedAck; mpuRefused_q |-> mpuAck_q; endproperty
  a_refusedAck: assert property (p_refusedAck) else $error("refusal without ack");
  property p_badAddr; mpuReq && mpuAddr[2:1] == 2'b01 |=> mpuRefused_q; endproperty
  a_badAddr: assert property (p_badAddr) else $error("reserved address accepted");
  property p_isoFollow; !$past(reset) && $past(clkEn) |-> isoState_q == $past(isoReq); endproperty
  a_isoFollow: assert property (p_isoFollow) else $error("isolation state lags");
  property p_statIso;
    mpuReq && mpuAddr == `ILF_ADDR_STAT |=> !mpuRefused_q && mpuRdata_q[`ILF_ST_ISO] == $past(isoState_q);
  endproperty
  a_statIso: assert property (p_statIso) else $error("status shows wrong isolation");
  property p_isoBlocksMpu; mpuReq && isoState_q && mpuAddr != `ILF_ADDR_STAT |=> mpuRefused_q; endproperty
  a_isoBlocksMpu: assert property (p_isoBlocksMpu) else $error("access while isolated");
  property p_scsiIso; $rose(scsiAckOut_q) |-> $past(isoState_q) || $past(isoState_q, 2); endproperty
  a_scsiIso: assert property (p_scsiIso) else $error("SCSI transfer without isolation");
  property p_scsiPar; scsiAckOut_q && scsiDataOe_q |-> ^{scsiDataOut_q, scsiParOut_q}; endproperty
  a_scsiPar: assert property (p_scsiPar) else $error("SCSI parity not odd");
  property p_txHold;
    lnkTxValid_q && !lnkTxReady |=> lnkTxValid_q && $stable(lnkTxData_q) && $stable(lnkTxLast_q);
  endproperty
  a_txHold: assert property (p_txHold) else $error("link word not held");
  property p_ledOn; diskSpeedIn [*4] |=> led_q; endproperty
  a_ledOn: assert property (p_ledOn) else $error("indicator dark at speed");
  property p_ledOff; (!diskSpinIn && !diskSpeedIn) [*4] |=> !led_q; endproperty
  a_ledOff: assert property (p_ledOff) else $error("indicator lit when stopped");
  c_scsiOut: cover property (scsiAckOut_q && scsiDataOe_q);
  c_refused: cover property (mpuRefused_q);
  c_txLast: cover property (lnkTxValid_q && lnkTxReady && lnkTxLast_q);
endmodule // ilf_datapath_chk
bind ilf_datapath ilf_datapath_chk u_chk (.ref_clk(ref_clk), .reset(reset), .lnkTxReady(lnkTxReady),
  .lnkTxValid_q(lnkTxValid_q), .lnkTxData_q(lnkTxData_q), .lnkTxLast_q(lnkTxLast_q),
  .scsiDataOut_q(scsiDataOut_q), .scsiParOut_q(scsiParOut_q), .scsiDataOe_q(scsiDataOe_q),
  .scsiAckOut_q(scsiAckOut_q), .isoReq(isoReq), .isoState_q(isoState_q), .mpuReq(mpuReq), .mpuAddr(mpuAddr),
  .mpuAck_q(mpuAck_q), .mpuRefused_q(mpuRefused_q), .mpuRdata_q(mpuRdata_q), .errClr(errClr), .err_q(err_q),
  .diskSpinIn(diskSpinIn), .diskSpeedIn(diskSpeedIn), .led_q(led_q), .clkEn(clkEn));

// *** verif/ilf_link_partner.sv ***
// Behavioural model of the computing-module port card on the link.
`timescale 1ns/1ns
`include "ilf_defs.vh"
module ilf_link_partner (
  input  logic       ref_clk,
  output logic       lnkRxValid,
  output logic [7:0] lnkRxData,
  output logic       lnkRxLast,
  input  logic       lnkRxReady,
  input  logic       lnkTxValid_q,
  input  logic [7:0] lnkTxData_q,
  input  logic       lnkTxLast_q,
  output logic       lnkTxReady
);
  logic [8:0] gotQ[$];
  logic       slow = 1'b0;
  integer     seed = 82990;
  initial begin
    lnkRxValid = 1'b0;
    lnkRxData = 8'h00;
    lnkRxLast = 1'b0;
    lnkTxReady = 1'b0;
  end
  function automatic logic [7:0] crc8(input logic [7:0] blk[$]);
    logic [7:0] c;
    c = `ILF_CRC_INIT;
    foreach (blk[i]) begin
      c = c ^ blk[i];
      for (int b = 0; b < 8; b++) c = c[7] ? ({c[6:0], 1'b0} ^ `ILF_CRC_POLY) : {c[6:0], 1'b0};
    end
    return c;
  endfunction
  // Sends a block and its check word, each held until the device takes it.
  task automatic send_block(input logic [7:0] blk[$], input logic bad);
    logic [7:0] w[$];
    w = blk;
    w.push_back(crc8(blk) ^ {7'h00, bad});
    foreach (w[i]) begin
      lnkRxValid = 1'b1;
      lnkRxData = w[i];
      lnkRxLast = (i == w.size() - 1);
      do @(negedge ref_clk); while (!lnkRxReady);
      @(posedge ref_clk);
      #1;
    end
    lnkRxValid = 1'b0;
    lnkRxLast = 1'b0;
    lnkRxData = ~lnkRxData;
  endtask
  // Takes transmitted words, stalling at random when slow.
  always @(posedge ref_clk) begin
    if (lnkTxValid_q && lnkTxReady) gotQ.push_back({lnkTxLast_q, lnkTxData_q});
    lnkTxReady <= #1 slow ? 1'($random(seed)) : 1'b1;
  end
endmodule // ilf_link_partner

// *** verif/ilf_datapath_tb_top.sv ***
// Self-checking bench of the image loader FIFO datapath.
`timescale 1ns/1ns
`include "ilf_defs.vh"
module ilf_datapath_tb_top;
  localparam int DEPTH = 8;
  logic        ref_clk, reset, clkEn, lnkRxValid, lnkRxLast, lnkRxReady, lnkTxStart, lnkTxReady;
  logic        lnkTxValid_q, lnkTxLast_q, scsiDmaEn, scsiReqIn, scsiDirIn, scsiParIn, scsiParOut_q;
  logic        scsiDataOe_q, scsiAckOut_q, isoReq, isoState_q, mpuReq, mpuWr, mpuAck_q, mpuRefused_q;
  logic        diskSpinIn, diskSpeedIn, led_q, refd, prev;
  logic [2:0]  mpuAddr, errClr, err_q;
  logic [7:0]  lnkRxData, lnkTxData_q, scsiDataIn, scsiDataOut_q, mpuWdata, mpuRdata_q, rd, d;
  logic [15:0] lnkTxLen;
  logic [7:0]  expQ[$], blk[$];
  integer      failures = 0, n_checks = 0, cycles = 0, seed = 82990, k, n;
  ilf_datapath #(.DEPTH(DEPTH), .AW(3), .BLINK_HALF(4)) i_dut (.ref_clk(ref_clk), .reset(reset), .clkEn(clkEn),
    .lnkRxValid(lnkRxValid), .lnkRxData(lnkRxData), .lnkRxLast(lnkRxLast), .lnkRxReady(lnkRxReady),
    .lnkTxStart(lnkTxStart), .lnkTxLen(lnkTxLen), .lnkTxReady(lnkTxReady), .lnkTxValid_q(lnkTxValid_q),
    .lnkTxData_q(lnkTxData_q), .lnkTxLast_q(lnkTxLast_q), .scsiDmaEn(scsiDmaEn), .scsiReqIn(scsiReqIn),
    .scsiDirIn(scsiDirIn), .scsiDataIn(scsiDataIn), .scsiParIn(scsiParIn), .scsiDataOut_q(scsiDataOut_q),
    .scsiParOut_q(scsiParOut_q), .scsiDataOe_q(scsiDataOe_q), .scsiAckOut_q(scsiAckOut_q), .isoReq(isoReq),
    .isoState_q(isoState_q), .mpuReq(mpuReq), .mpuWr(mpuWr), .mpuAddr(mpuAddr), .mpuWdata(mpuWdata),
    .mpuAck_q(mpuAck_q), .mpuRefused_q(mpuRefused_q), .mpuRdata_q(mpuRdata_q), .errClr(errClr), .err_q(err_q),
    .diskSpinIn(diskSpinIn), .diskSpeedIn(diskSpeedIn), .led_q(led_q));
  ilf_link_partner i_part (.ref_clk(ref_clk), .lnkRxValid(lnkRxValid), .lnkRxData(lnkRxData),
    .lnkRxLast(lnkRxLast), .lnkRxReady(lnkRxReady), .lnkTxValid_q(lnkTxValid_q), .lnkTxData_q(lnkTxData_q),
    .lnkTxLast_q(lnkTxLast_q), .lnkTxReady(lnkTxReady));
  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end
  task tick;
    @(posedge ref_clk);
    #1;
  endtask
  task chk(input logic [7:0] got, input logic [7:0] exp, input string m);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("ERROR %0t %s", $time, m);
    end
  endtask
  task wrap_up;
    if (failures == 0 && n_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task mpu(input logic w, input logic [2:0] a, input logic [7:0] wd);
    mpuReq = 1'b1;
    mpuWr = w;
    mpuAddr = a;
    mpuWdata = wd;
    tick;
    chk(8'(mpuAck_q), 8'h01, "no processor ack");
    rd = mpuRdata_q;
    refd = mpuRefused_q;
    mpuReq = 1'b0;
    tick;
  endtask
  // One target handshake; refd is set when the device never answers.
  task scsi(input logic dir, input logic [7:0] wd, input logic bad);
    scsiDirIn = dir;
    scsiDataIn = dir ? wd : ~scsiDataIn;
    scsiParIn = ~^wd ^ bad;
    scsiReqIn = 1'b1;
    k = 0;
    while (!scsiAckOut_q && k < 20) begin
      tick;
      k++;
    end
    refd = !scsiAckOut_q;
    rd = scsiDataOut_q;
    if (!refd && !dir) chk(8'({scsiDataOe_q, ^{rd, scsiParOut_q}}), 8'h03, "bad SCSI drive or parity");
    scsiReqIn = 1'b0;
    scsiDataIn = ~scsiDataIn;
    k = 0;
    while (scsiAckOut_q && k < 20) begin
      tick;
      k++;
    end
    chk(8'(scsiAckOut_q), 8'h00, "SCSI ack stuck");
  endtask
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      $display("ERROR %0t timeout", $time);
      wrap_up;
    end
  end
  initial begin
    {clkEn, reset, lnkTxStart, scsiDmaEn, scsiReqIn, scsiDirIn, scsiParIn, isoReq, mpuReq, mpuWr} = 10'h300;
    {diskSpinIn, diskSpeedIn, lnkTxLen, scsiDataIn, mpuAddr, mpuWdata, errClr} = 40'h0;
    repeat (3) @(posedge ref_clk);
    #1;
    reset = 1'b0;
    tick;
    mpu(1'b0, `ILF_ADDR_STAT, 8'h00);
    chk(rd, 8'h00, "status after reset");
    mpu(1'b1, 3'h2, 8'h5A);
    chk(8'(refd), 8'h01, "reserved address taken");
    mpu(1'b0, `ILF_ADDR_FIFO, 8'h00);
    chk(8'(refd), 8'h01, "empty bank read taken");
    mpu(1'b1, 3'h4, 8'hA5);
    mpu(1'b0, 3'h4, 8'h00);
    chk(rd, 8'hA5, "SCSI register readback");
    for (n = 0; n < 5; n++) blk.push_back(8'($random(seed)));
    expQ = blk;
    i_part.send_block(blk, 1'b0);
    tick;
    chk(8'(err_q), 8'h00, "good CRC flagged");
    blk.delete();
    i_part.send_block(blk, 1'b1);
    repeat (3) tick;
    chk(8'(err_q), 8'h01, "bad CRC missed");
    errClr = 3'h1;
    tick;
    errClr = 3'h0;
    tick;
    chk(8'(err_q), 8'h00, "CRC error not cleared");
    refd = 1'b0;
    for (n = 0; n < 20 && !refd; n++) begin
      d = 8'($random(seed));
      mpu(1'b1, `ILF_ADDR_FIFO, d);
      if (!refd) expQ.push_back(d);
    end
    chk(8'(expQ.size()), 8'(DEPTH), "bank depth");
    chk(8'(lnkRxReady), 8'h00, "link ready with full bank");
    isoReq = 1'b1;
    scsiDmaEn = 1'b1;
    tick;
    mpu(1'b1, 3'h4, 8'h11);
    chk(8'(refd), 8'h01, "access while isolated");
    mpu(1'b0, `ILF_ADDR_STAT, 8'h00);
    chk(8'(rd[`ILF_ST_ISO]), 8'h01, "isolation status");
    while (expQ.size() > 0) begin
      scsi(1'b0, 8'h00, 1'b0);
      chk(rd, expQ.pop_front(), "SCSI out byte");
    end
    scsi(1'b0, 8'h00, 1'b0);
    chk(8'(refd), 8'h01, "SCSI out from empty bank");
    for (n = 0; n < 6; n++) begin
      d = 8'($random(seed));
      expQ.push_back(d);
      scsi(1'b1, d, 1'b0);
    end
    chk(8'(err_q), 8'h00, "good parity flagged");
    isoReq = 1'b0;
    i_part.slow = 1'b1;
    lnkTxLen = 16'h0006;
    lnkTxStart = 1'b1;
    tick;
    lnkTxStart = 1'b0;
    for (n = 0; n < 400 && i_part.gotQ.size() < 7; n++) tick;
    blk = expQ;
    expQ.push_back(i_part.crc8(blk));
    foreach (expQ[i]) chk(i_part.gotQ[i][7:0], expQ[i], "link word");
    chk(8'(i_part.gotQ[6][8]), 8'h01, "check word not marked last");
    isoReq = 1'b1;
    tick;
    scsi(1'b1, 8'h3C, 1'b1);
    tick;
    chk(8'(err_q), 8'h02, "SCSI parity error missed");
    isoReq = 1'b0;
    tick;
    mpu(1'b0, `ILF_ADDR_FIFO, 8'h00);
    chk(rd, 8'h3C, "test port read of receive bank");
    chk(8'(err_q), 8'h02, "stored word parity flagged");
    diskSpeedIn = 1'b1;
    repeat (8) tick;
    chk(8'(led_q), 8'h01, "indicator not steady");
    diskSpeedIn = 1'b0;
    diskSpinIn = 1'b1;
    k = 0;
    repeat (40) begin
      prev = led_q;
      tick;
      if (led_q !== prev) k++;
    end
    chk(8'(k >= 4), 8'h01, "indicator not flashing");
    diskSpinIn = 1'b0;
    repeat (8) tick;
    chk(8'(led_q), 8'h00, "indicator not dark");
    clkEn = 1'b0;
    isoReq = 1'b1;
    repeat (3) tick;
    chk(8'(isoState_q), 8'h00, "state moved while frozen");
    clkEn = 1'b1;
    tick;
    chk(8'(isoState_q), 8'h01, "isolation state lags after freeze");
    wrap_up;
  end
endmodule // ilf_datapath_tb_top
